//--- hdl/ppr_params.svh
// Offsets, field positions, reset values and counts of the pin router
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH
`define PPR_NUM_IN_SEL 29
`define PPR_NUM_PINS 18
`define PPR_NUM_SRC 32
`define PPR_ADDR_W 8
`define PPR_IN_SEL_BASE 8'h00
`define PPR_OUT_SEL_BASE 8'h20
`define PPR_LOCK_OFS 8'h40
`define PPR_CFG_OFS 8'h41
`define PPR_SEL_MSB 4
`define PPR_LOCK_BIT 0
`define PPR_UNLOCK_KEY1 8'h55
`define PPR_UNLOCK_KEY2 8'haa
`define PPR_OUT_RESET 5'h00
`define PPR_IN_RESET_DEFAULT 5'h00
`define PPR_PORTA_PIN3 3
`endif

//--- hdl/ppr_pkg.sv
// Types shared by the pin router
package ppr_pkg;
  typedef enum logic [1:0] {
    PPR_KEY_IDLE = 2'b00,
    PPR_KEY_GOT1 = 2'b01,
    PPR_KEY_OPEN = 2'b11
  } ppr_key_t;
  typedef logic [4:0] ppr_sel_t;
endpackage

//--- hdl/ppr_pin_router.sv
// Pin router: selectors, lock, Avalon-MM slave and signal routing
// Overview of operation
// - Selections held through sleep state
// - Power-on reset restores defaults, clears lock
// - Other resets keep routing selections
// - Input selector: 5-bit code, upper bits zero
// - Input codes 0-5 pick port A pins
// - Codes 12-15 pick port B 4-7
// - Codes 16-23 pick port C pins
// - Input defaults per peripheral at power-on
// - Output selector 5-bit, zero at power-on
// - Codes 0-1 port latch; 2-3 pulse outputs
// - Codes 4-7 logic cell outputs
// - Codes 8-11, 16-19 waveform generators
// - Codes 12-15 capture/compare units
// - Serial async/sync and comparator outputs
// - Serial port clock and data outputs
// - Timer, oscillator, ref clock, modulator
// - Bidirectional sources override pin direction
// - Lock bit in bit 0 blocks changes
// - One-shot config: set lock not clearable after a toggle
// - Registers readable regardless of lock
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "ppr_params.svh"
module ppr_pin_router #(
  parameter int NUM_IN = `PPR_NUM_IN_SEL,
  parameter int NUM_PINS = `PPR_NUM_PINS,
  parameter logic [5*`PPR_NUM_IN_SEL-1:0] IN_DEFAULTS = '0
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic sleep_in,
  input wire logic one_shot_lock_cfg_in,
  input wire logic [`PPR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [`PPR_NUM_SRC-1:0] periph_src_in,
  input wire logic [`PPR_NUM_SRC-1:0] periph_src_oe_in,
  input wire logic [`PPR_NUM_SRC-1:0] periph_src_ovr_in,
  input wire logic [NUM_PINS-1:0] pin_latch_in,
  input wire logic [NUM_PINS-1:0] pin_direction_ctl_in,
  input wire logic [23:0] pin_level_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_out,
  output logic [NUM_IN-1:0] periph_in_out,
  output logic route_locked_bit_out
);
  // Register slot hit; one compare shared by writes and reads
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] base, input int idx);
    return a == base + 8'(idx);
  endfunction

  // Legal input codes; reserved ones route nothing
  function automatic logic in_code_ok(input ppr_pkg::ppr_sel_t sel);
    logic ok;
    ok = 1'b0;
    case (sel)
      5'h00: ok = 1'b1;
      5'h01: ok = 1'b1;
      5'h02: ok = 1'b1;
      5'h03: ok = 1'b1;
      5'h04: ok = 1'b1;
      5'h05: ok = 1'b1;
      5'h0c: ok = 1'b1;
      5'h0d: ok = 1'b1;
      5'h0e: ok = 1'b1;
      5'h0f: ok = 1'b1;
      5'h10: ok = 1'b1;
      5'h11: ok = 1'b1;
      5'h12: ok = 1'b1;
      5'h13: ok = 1'b1;
      5'h14: ok = 1'b1;
      5'h15: ok = 1'b1;
      5'h16: ok = 1'b1;
      5'h17: ok = 1'b1;
      // Reserved codes read low rather than float
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Output codes that hand the pin to a peripheral
  function automatic logic src_code_used(input ppr_pkg::ppr_sel_t sel);
    logic used;
    used = 1'b0;
    case (sel)
      // Pulse outputs; 0 and 1 stay on latch
      5'h02: used = 1'b1;
      5'h03: used = 1'b1;
      5'h04: used = 1'b1;
      5'h05: used = 1'b1;
      5'h06: used = 1'b1;
      5'h07: used = 1'b1;
      5'h08: used = 1'b1;
      5'h09: used = 1'b1;
      5'h0a: used = 1'b1;
      5'h0b: used = 1'b1;
      5'h0c: used = 1'b1;
      5'h0d: used = 1'b1;
      5'h0e: used = 1'b1;
      5'h0f: used = 1'b1;
      5'h10: used = 1'b1;
      5'h11: used = 1'b1;
      5'h12: used = 1'b1;
      5'h13: used = 1'b1;
      5'h14: used = 1'b1;
      5'h15: used = 1'b1;
      5'h16: used = 1'b1;
      5'h17: used = 1'b1;
      5'h18: used = 1'b1;
      5'h19: used = 1'b1;
      5'h1a: used = 1'b1;
      5'h1b: used = 1'b1;
      5'h1c: used = 1'b1;
      5'h1d: used = 1'b1;
      5'h1e: used = 1'b1;
      5'h1f: used = 1'b1;
      default: used = 1'b0;
    endcase
    return used;
  endfunction

  ppr_pkg::ppr_sel_t in_sel [NUM_IN];
  ppr_pkg::ppr_sel_t out_sel [NUM_PINS];
  logic lock_bit;
  logic toggle_used;
  ppr_pkg::ppr_key_t key_state;
  logic wr_ack;
  logic rd_ack;
  logic [31:0] rd_data;
  logic sel_wr_ok;
  ppr_pkg::ppr_key_t next_key_state;
  logic [NUM_IN-1:0] next_periph_in;
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;

  // Write lands only on the edge where the master sees waitrequest low
  wire logic bus_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire logic [7:0] wdata = avs_writedata_in[7:0];
  wire logic [7:0] adr = avs_address_in;
  wire logic lock_hit = bus_wr && adr == `PPR_LOCK_OFS;

  assign sel_wr_ok = bus_wr && !lock_bit && !sleep_in;

  // Power-on restores defaults; other resets keep selections
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < NUM_IN; i++) begin
      if (por_in) begin
        in_sel[i] <= IN_DEFAULTS[5*i +: 5];
      end else if (sel_wr_ok && reg_hit(adr, `PPR_IN_SEL_BASE, i)) begin
        in_sel[i] <= wdata[`PPR_SEL_MSB:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int j = 0; j < NUM_PINS; j++) begin
      if (por_in) begin
        out_sel[j] <= `PPR_OUT_RESET;
      end else if (sel_wr_ok && reg_hit(adr, `PPR_OUT_SEL_BASE, j)) begin
        out_sel[j] <= wdata[`PPR_SEL_MSB:0];
      end
    end
  end

  always_comb begin
    next_key_state = key_state;
    if (bus_wr) begin
      case (key_state)
        ppr_pkg::PPR_KEY_IDLE: begin
          if (lock_hit && wdata == `PPR_UNLOCK_KEY1) begin
            next_key_state = ppr_pkg::PPR_KEY_GOT1;
          end
        end
        ppr_pkg::PPR_KEY_GOT1: begin
          if (lock_hit && wdata == `PPR_UNLOCK_KEY2) begin
            next_key_state = ppr_pkg::PPR_KEY_OPEN;
          end else if (lock_hit && wdata == `PPR_UNLOCK_KEY1) begin
            next_key_state = ppr_pkg::PPR_KEY_GOT1;
          end else begin
            next_key_state = ppr_pkg::PPR_KEY_IDLE;
          end
        end
        // Key spent by whatever write follows it
        ppr_pkg::PPR_KEY_OPEN: begin
          next_key_state = ppr_pkg::PPR_KEY_IDLE;
        end
        default: begin
          next_key_state = ppr_pkg::PPR_KEY_IDLE;
        end
      endcase
    end
  end

  // Half-entered key never survives a system reset; power-on alone keeps it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_state <= ppr_pkg::PPR_KEY_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // Lock bit changed only after key
  // One-shot config: after a change, a set lock cannot be cleared until reset
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      toggle_used <= 1'b0;
    end else if (por_in) begin
      toggle_used <= 1'b0;
    end else if (lock_hit && key_state == ppr_pkg::PPR_KEY_OPEN
                 && wdata[`PPR_LOCK_BIT] != lock_bit) begin
      toggle_used <= 1'b1;
    end
  end

  // Lock survives non-power-on resets; power-on clears it
  always_ff @(posedge ref_clk_in) begin
    if (por_in) begin
      lock_bit <= 1'b0;
    end else if (lock_hit && key_state == ppr_pkg::PPR_KEY_OPEN
                 && !(one_shot_lock_cfg_in && toggle_used && lock_bit)) begin
      lock_bit <= wdata[`PPR_LOCK_BIT];
    end
  end

  // One-cycle wait on every access keeps read data registered
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ack <= 1'b0;
    end else begin
      wr_ack <= avs_write_in && !wr_ack;
    end
  end

  // Read answer marker; forces waitrequest high the cycle after each answer, so a held read is answered every other cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= avs_read_in && !rd_ack;
    end
  end

  // Reads always allowed; unmapped reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    for (int i = 0; i < NUM_IN; i++) begin
      if (reg_hit(adr, `PPR_IN_SEL_BASE, i)) begin
        rd_data = {27'h0000000, in_sel[i]};
      end
    end
    for (int j = 0; j < NUM_PINS; j++) begin
      if (reg_hit(adr, `PPR_OUT_SEL_BASE, j)) begin
        rd_data = {27'h0000000, out_sel[j]};
      end
    end
    if (adr == `PPR_LOCK_OFS) begin
      rd_data = {31'h00000000, lock_bit};
    end
    if (adr == `PPR_CFG_OFS) begin
      rd_data = {30'h00000000, toggle_used, one_shot_lock_cfg_in};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_readdata_out <= rd_data;
      avs_waitrequest_out <= !((avs_read_in && !rd_ack) || (avs_write_in && !wr_ack));
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      route_locked_bit_out <= 1'b0;
    end else begin
      route_locked_bit_out <= lock_bit;
    end
  end

  // Input pin selection, reserved codes read low
  always_comb begin
    next_periph_in = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (in_code_ok(in_sel[i])) begin
        next_periph_in[i] = pin_level_in[in_sel[i]];
      end
    end
  end

  // Registered so peripherals never see a decode glitch
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      periph_in_out <= '0;
    end else begin
      periph_in_out <= next_periph_in;
    end
  end

  // Source code indexes peripheral output vector
  // Every pin, port A pin 3 included, has an output slot
  always_comb begin
    next_pin_out = '0;
    next_pin_oe = '0;
    for (int j = 0; j < NUM_PINS; j++) begin
      if (src_code_used(out_sel[j])) begin
        next_pin_out[j] = periph_src_in[out_sel[j]];
        next_pin_oe[j] = periph_src_ovr_in[out_sel[j]]
                         ? periph_src_oe_in[out_sel[j]] : pin_direction_ctl_in[j];
      end else begin
        next_pin_out[j] = pin_latch_in[j];
        next_pin_oe[j] = pin_direction_ctl_in[j];
      end
    end
  end

  // Pin drivers off in system reset; selections themselves are kept
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_oe_out <= '0;
    end else begin
      pin_oe_out <= next_pin_oe;
    end
  end
endmodule

//--- sim/ppr_pin_router_props.sv
// Checker for the pin router bus and lock
`timescale 1ns/100ps
module ppr_pin_router_props #(
  parameter int NUM_PINS = 18
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [NUM_PINS-1:0] pin_latch_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic route_locked_bit_out
);
  wire ok = avs_read_in && !avs_waitrequest_out;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ans; avs_read_in && avs_waitrequest_out |-> ##[1:4] !avs_waitrequest_out; endproperty
  a_ans: assert property (p_ans) else $error("read unanswered");
  property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_sel; ok && avs_address_in < 8'h40 |-> avs_readdata_out[31:5] == 27'h0; endproperty
  a_sel: assert property (p_sel) else $error("selector high bits");
  property p_lkz; ok && avs_address_in == 8'h40 |-> avs_readdata_out[31:1] == 31'h0; endproperty
  a_lkz: assert property (p_lkz) else $error("lock high bits");
  property p_lkb; ok && avs_address_in == 8'h40 |-> avs_readdata_out[0] == route_locked_bit_out;
  endproperty
  a_lkb: assert property (p_lkb) else $error("lock read mismatch");
  // Lock flop clears on the por edge, its output copy one edge later
  property p_por; por_in |-> ##2 !route_locked_bit_out; endproperty
  a_por: assert property (p_por) else $error("lock kept over por");
  property p_map; ok && avs_address_in inside {[8'h32:8'h3f]} |-> avs_readdata_out == 32'h0;
  endproperty
  a_map: assert property (p_map) else $error("unmapped read nonzero");
  property p_lat; por_in [*2] |=> pin_out == $past(pin_latch_in); endproperty
  a_lat: assert property (p_lat) else $error("pin not on latch");
  c_lock: cover property ($rose(route_locked_bit_out));
  c_por: cover property (por_in [*2]);
  c_rd: cover property (ok && avs_address_in == 8'h40);
endmodule
bind ppr_pin_router ppr_pin_router_props #(.NUM_PINS(NUM_PINS)) u_props (.ref_clk_in, .rst_in,
  .por_in, .avs_address_in, .avs_read_in, .avs_readdata_out, .avs_waitrequest_out,
  .pin_latch_in, .pin_out, .route_locked_bit_out);

//--- sim/ppr_periph_model.sv
// Peripheral outputs and pin levels
`timescale 1ns/100ps
module ppr_periph_model (
  input wire logic phase_in,
  output logic [31:0] src_out,
  output logic [31:0] src_oe_out,
  output logic [31:0] src_ovr_out,
  output logic [17:0] latch_out,
  output logic [17:0] dir_out,
  output logic [23:0] level_out
);
  // Sources, enables, latches and levels flip with phase so a stuck route shows
  assign src_out = 32'h6b2d_91e4 ^ {32{phase_in}};
  assign src_oe_out = 32'h3c5a_0f96 ^ {32{phase_in}};
  assign src_ovr_out = 32'h0f30_0000;
  assign latch_out = 18'h2_9a5c ^ {18{phase_in}};
  assign dir_out = 18'h1_65a3;
  assign level_out = 24'hc3_a596 ^ {24{phase_in}};
endmodule

//--- sim/ppr_pin_router_tb.sv
// Self-checking bench for the pin router
`timescale 1ns/100ps
module ppr_pin_router_tb;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1, slp = 1'b0, rd = 1'b0, wr = 1'b0, ph = 1'b0;
  logic cfg = 1'b0;
  logic wt, lck;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, q, rdat, src, soe, sovr;
  logic [17:0] lat, dir, pout, poe;
  logic [23:0] lvl;
  logic [28:0] pin_in;
  int error_cnt = 0, n_tests = 0;
  logic [7:0] rows [5][3] = '{'{8'h00, 8'hff, 8'h1f}, '{8'h1c, 8'h17, 8'h17},
    '{8'h20, 8'he5, 8'h05}, '{8'h31, 8'h1f, 8'h1f}, '{8'h35, 8'h12, 8'h00}};
  ppr_pin_router dut (.ref_clk_in(clk), .rst_in(rst), .por_in(por), .sleep_in(slp),
    .one_shot_lock_cfg_in(cfg), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'h1), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wt), .periph_src_in(src), .periph_src_oe_in(soe),
    .periph_src_ovr_in(sovr), .pin_latch_in(lat), .pin_direction_ctl_in(dir),
    .pin_level_in(lvl), .pin_out(pout), .pin_oe_out(poe), .periph_in_out(pin_in),
    .route_locked_bit_out(lck));
  ppr_periph_model peri (.phase_in(ph), .src_out(src), .src_oe_out(soe), .src_ovr_out(sovr),
    .latch_out(lat), .dir_out(dir), .level_out(lvl));
  initial forever #2 clk = ~clk;
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask
  // Held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task lock_wr(input logic [7:0] v);
    bus(1'b1, 8'h40, 8'h55);
    bus(1'b1, 8'h40, 8'haa);
    bus(1'b1, 8'h40, v);
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // About 25 times the expected run
  initial begin
    #40000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][0], rows[i][1]);
      bus(1'b0, rows[i][0], 8'h00);
      chk("readback", {24'h0, rows[i][2]}, q);
    end
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, 8'h20, c[7:0]);
      bus(1'b1, 8'h00, c[7:0]);
      ph <= c[0];
      repeat (3) @(negedge clk);
      chk("pin", (c < 2) ? lat[0] : src[c], pout[0]);
      chk("oe", (c > 1 && sovr[c]) ? soe[c] : dir[0], poe[0]);
      chk("in", (c < 6 || c inside {[12:23]}) ? lvl[c] : 1'b0, pin_in[0]);
      @(posedge clk);
    end
    // Keyed lock, then an unkeyed clear that must be dropped
    lock_wr(8'h01);
    bus(1'b1, 8'h40, 8'h00);
    bus(1'b1, 8'h21, 8'h09);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h40, 8'h00);
    chk("lock", 32'h1, q);
    bus(1'b0, 8'h21, 8'h00);
    chk("locked write", 32'h0, q);
    bus(1'b0, 8'h31, 8'h00);
    chk("kept", 32'h1f, q);
    por <= 1'b1;
    repeat (2) @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    bus(1'b0, 8'h40, 8'h00);
    chk("lock por", 32'h0, q);
    bus(1'b0, 8'h31, 8'h00);
    chk("out por", 32'h0, q);
    bus(1'b0, 8'h00, 8'h00);
    chk("in por", 32'h0, q);
    slp <= 1'b1;
    bus(1'b1, 8'h22, 8'h07);
    bus(1'b0, 8'h22, 8'h00);
    chk("sleep", 32'h0, q);
    slp <= 1'b0;
    // One-shot config: lock set once, later clear refused
    cfg <= 1'b1;
    lock_wr(8'h01);
    lock_wr(8'h00);
    bus(1'b0, 8'h40, 8'h00);
    chk("one shot", 32'h1, q);
    bus(1'b0, 8'h41, 8'h00);
    chk("status", 32'h3, q);
    final_report;
  end
endmodule
